// [inc/rbs_pkg.sv]
// Purpose: constants for the return and bit-set execution slice
// Assumes: 10-bit instruction words, 4-bit data nibbles
// Notes: register offsets are byte addresses on a 32-bit APB
package rbs_pkg;
    // instruction encodings
    localparam logic [9:0] OP_SUBROUTINE_RETURN = 10'h044;
    localparam logic [9:0] OP_RETURN_SKIP = 10'h045;
    localparam logic [9:0] OP_INTERRUPT_RETURN = 10'h046;
    localparam logic [9:0] OP_TABLE_BANK_SET = 10'h041;
    localparam logic [7:0] OP_MEMORY_BIT_SET_HI = 8'h17;
    // widths
    localparam int PC_W = 14;
    localparam int DMEM_AW = 10;
    // register byte offsets
    localparam logic [7:0] OFS_PC = 8'h00;
    localparam logic [7:0] OFS_SP = 8'h04;
    localparam logic [7:0] OFS_PTR = 8'h08;
    localparam logic [7:0] OFS_ACC = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MEM = 8'h14;
    localparam logic [7:0] OFS_STACK = 8'h18;
    localparam logic [7:0] OFS_INT = 8'h1C;
    // status field positions
    localparam int ST_SKIP = 0;
    localparam int ST_NOP = 1;
    localparam int ST_LA_SUP = 2;
    localparam int ST_LXY_SUP = 3;
    localparam int ST_BANK = 4;
    localparam int ST_CARRY = 5;
    localparam int ST_BUSY = 6;
    // reset values
    localparam logic [PC_W-1:0] RST_PC = 14'h0000;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    // cycle counts
    localparam int RETURN_CYCLES = 2;
    localparam int BIT_SET_CYCLES = 1;
    typedef enum logic [0:0] {RBS_IDLE = 1'b0, RBS_RET = 1'b1} rbs_state_t;
endpackage : rbs_pkg

// [hw/rbs_exec.sv]
// Purpose: executes return, return-and-skip, interrupt return, bit set and bank set
// Assumes: instruction port and table-read strobe come from logic on CLK_I
// Notes: APB answers with no wait state; bad addresses report pslverr
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module rbs_exec
    import rbs_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // instruction port
    input wire logic INSTR_VALID_I,
    input wire logic [9:0] INSTR_I,
    output logic INSTR_READY_O,
    output logic DONE_O,
    // table reference read
    input wire logic TABLE_READ_I,
    output logic TABLE_PAGE_HI_O,
    // state view
    output logic [PC_W-1:0] PC_O,
    output logic SKIP_O
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= OFS_INT);
    endfunction : is_mapped

    rbs_state_t state_q, state_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [PC_W-1:0] stack_d [STACK_DEPTH];
    logic [3:0] dmem_q [2**DMEM_AW];
    logic [3:0] x_q, x_d, y_q, y_d, a_q, a_d, b_q, b_d;
    logic [1:0] z_q, z_d;
    logic skip_q, skip_d, nop_q, nop_d, la_q, la_d, lxy_q, lxy_d;
    logic bank_q, bank_d, carry_q, carry_d;
    // interrupt snapshot
    logic [3:0] sx_q, sx_d, sy_q, sy_d, sa_q, sa_d, sb_q, sb_d;
    logic [1:0] sz_q, sz_d;
    logic ss_q, ss_d, sn_q, sn_d, sla_q, sla_d, slxy_q, slxy_d;
    logic [1:0] op_q, op_d;
    logic done_q, done_d, page_q, page_d;
    logic [31:0] prdata_q, prdata_d;
    logic slverr_q, slverr_d;
    logic mem_we;
    logic [DMEM_AW-1:0] mem_addr;
    logic [3:0] mem_wdata;
    logic take, apb_setup, apb_wr;

    assign take = INSTR_VALID_I && (state_q == RBS_IDLE);
    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && is_mapped(PADDR_I);
    assign mem_addr = {z_q, x_q, y_q};

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        sp_d = sp_q;
        stack_d = stack_q;
        x_d = x_q;
        y_d = y_q;
        z_d = z_q;
        a_d = a_q;
        b_d = b_q;
        skip_d = skip_q;
        nop_d = nop_q;
        la_d = la_q;
        lxy_d = lxy_q;
        bank_d = bank_q;
        carry_d = carry_q;
        sx_d = sx_q;
        sy_d = sy_q;
        sz_d = sz_q;
        sa_d = sa_q;
        sb_d = sb_q;
        ss_d = ss_q;
        sn_d = sn_q;
        sla_d = sla_q;
        slxy_d = slxy_q;
        op_d = op_q;
        done_d = 1'b0;
        page_d = page_q;
        mem_we = 1'b0;
        mem_wdata = dmem_q[mem_addr];
        // table read consumes the bank flag
        if (TABLE_READ_I) begin
            page_d = bank_q;
            bank_d = 1'b0;
        end
        case (state_q)
            RBS_IDLE: begin
                if (take && skip_q) begin
                    skip_d = 1'b0;
                    done_d = 1'b1;
                end else if (take) begin
                    case (INSTR_I)
                        OP_SUBROUTINE_RETURN, OP_RETURN_SKIP, OP_INTERRUPT_RETURN: begin
                            op_d = INSTR_I[1:0];
                            state_d = RBS_RET;
                        end
                        OP_TABLE_BANK_SET: begin
                            bank_d = 1'b1;
                            done_d = 1'b1;
                        end
                        default: begin
                            if (INSTR_I[9:2] == OP_MEMORY_BIT_SET_HI) begin
                                mem_wdata[INSTR_I[1:0]] = 1'b1;
                                mem_we = 1'b1;
                            end
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            RBS_RET: begin
                pc_d = stack_q[sp_q];
                sp_d = sp_q - 1'b1;
                done_d = 1'b1;
                state_d = RBS_IDLE;
                if (op_q == OP_RETURN_SKIP[1:0]) begin
                    skip_d = 1'b1;
                end
                if (op_q == OP_INTERRUPT_RETURN[1:0]) begin
                    x_d = sx_q;
                    y_d = sy_q;
                    z_d = sz_q;
                    skip_d = ss_q;
                    nop_d = sn_q;
                    la_d = sla_q;
                    lxy_d = slxy_q;
                    a_d = sa_q;
                    b_d = sb_q;
                end
            end
            default: begin
                state_d = RBS_IDLE;
            end
        endcase
        // software writes land last
        if (apb_wr) begin
            case (PADDR_I)
                OFS_PC: pc_d = PWDATA_I[PC_W-1:0];
                OFS_SP: sp_d = PWDATA_I[SP_W-1:0];
                OFS_PTR: begin
                    x_d = PWDATA_I[3:0];
                    y_d = PWDATA_I[7:4];
                    z_d = PWDATA_I[9:8];
                end
                OFS_ACC: begin
                    a_d = PWDATA_I[3:0];
                    b_d = PWDATA_I[7:4];
                end
                OFS_STATUS: begin
                    skip_d = PWDATA_I[ST_SKIP];
                    nop_d = PWDATA_I[ST_NOP];
                    la_d = PWDATA_I[ST_LA_SUP];
                    lxy_d = PWDATA_I[ST_LXY_SUP];
                    bank_d = PWDATA_I[ST_BANK] || bank_d;
                    carry_d = PWDATA_I[ST_CARRY];
                end
                OFS_MEM: begin
                    mem_wdata = PWDATA_I[3:0];
                    mem_we = 1'b1;
                end
                OFS_STACK: stack_d[sp_q] = PWDATA_I[PC_W-1:0];
                OFS_INT: begin
                    if (PWDATA_I[0]) begin
                        sp_d = sp_q + 1'b1;
                        stack_d[sp_q + 1'b1] = pc_q;
                        sx_d = x_q;
                        sy_d = y_q;
                        sz_d = z_q;
                        sa_d = a_q;
                        sb_d = b_q;
                        ss_d = skip_q;
                        sn_d = nop_q;
                        sla_d = la_q;
                        slxy_d = lxy_q;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (apb_setup) begin
            slverr_d = !is_mapped(PADDR_I);
            prdata_d = 32'h0000_0000;
            case (PADDR_I)
                OFS_PC: prdata_d[PC_W-1:0] = pc_q;
                OFS_SP: prdata_d[SP_W-1:0] = sp_q;
                OFS_PTR: prdata_d[9:0] = {z_q, y_q, x_q};
                OFS_ACC: prdata_d[7:0] = {b_q, a_q};
                OFS_STATUS: begin
                    prdata_d[ST_SKIP] = skip_q;
                    prdata_d[ST_NOP] = nop_q;
                    prdata_d[ST_LA_SUP] = la_q;
                    prdata_d[ST_LXY_SUP] = lxy_q;
                    prdata_d[ST_BANK] = bank_q;
                    prdata_d[ST_CARRY] = carry_q;
                    prdata_d[ST_BUSY] = (state_q != RBS_IDLE);
                end
                OFS_MEM: prdata_d[3:0] = dmem_q[mem_addr];
                OFS_STACK: prdata_d[PC_W-1:0] = stack_q[sp_q];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (mem_we) begin
            dmem_q[mem_addr] <= mem_wdata;
        end
        stack_q <= stack_d;
        sx_q <= sx_d;
        sy_q <= sy_d;
        sz_q <= sz_d;
        sa_q <= sa_d;
        sb_q <= sb_d;
        ss_q <= ss_d;
        sn_q <= sn_d;
        sla_q <= sla_d;
        slxy_q <= slxy_d;
        op_q <= op_d;
        if (RST_I) begin
            state_q <= RBS_IDLE;
            pc_q <= RST_PC;
            sp_q <= '0;
            x_q <= RST_NIBBLE;
            y_q <= RST_NIBBLE;
            z_q <= 2'h0;
            a_q <= RST_NIBBLE;
            b_q <= RST_NIBBLE;
            skip_q <= 1'b0;
            nop_q <= 1'b0;
            la_q <= 1'b0;
            lxy_q <= 1'b0;
            bank_q <= 1'b0;
            carry_q <= 1'b0;
            done_q <= 1'b0;
            page_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            x_q <= x_d;
            y_q <= y_d;
            z_q <= z_d;
            a_q <= a_d;
            b_q <= b_d;
            skip_q <= skip_d;
            nop_q <= nop_d;
            la_q <= la_d;
            lxy_q <= lxy_d;
            bank_q <= bank_d;
            carry_q <= carry_d;
            done_q <= done_d;
            page_q <= page_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = PSEL_I && PENABLE_I;
    assign PSLVERR_O = PSEL_I && PENABLE_I && slverr_q;
    assign INSTR_READY_O = (state_q == RBS_IDLE);
    assign DONE_O = done_q;
    assign TABLE_PAGE_HI_O = page_q;
    assign PC_O = pc_q;
    assign SKIP_O = skip_q;
endmodule : rbs_exec

// [tb/rbs_exec_sva.sv]
// Purpose: port assertions for rbs_exec
// Assumes: one clock, synchronous reset
// Notes: bound after the module
`timescale 1ns/100ps
module rbs_exec_sva
    import rbs_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic PSLVERR_O,
    // core
    input wire logic INSTR_VALID_I,
    input wire logic [9:0] INSTR_I,
    input wire logic INSTR_READY_O,
    input wire logic DONE_O,
    input wire logic TABLE_READ_I,
    input wire logic TABLE_PAGE_HI_O,
    input wire logic SKIP_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    logic tk;
    logic bk;
    assign tk = INSTR_VALID_I && INSTR_READY_O && !SKIP_O;
    assign bk = tk && INSTR_I == OP_TABLE_BANK_SET;
    a_ret_timing: assert property (tk && INSTR_I == OP_SUBROUTINE_RETURN |=> !INSTR_READY_O ##1 DONE_O)
        else $error("return timing wrong");
    a_ret_noskip: assert property (tk && INSTR_I == OP_SUBROUTINE_RETURN |-> ##2 !SKIP_O)
        else $error("plain return set skip");
    a_skip_set: assert property (tk && INSTR_I == OP_RETURN_SKIP |-> ##2 SKIP_O)
        else $error("return skip did not set skip");
    a_skip_discard: assert property (INSTR_VALID_I && INSTR_READY_O && SKIP_O |=> DONE_O && !SKIP_O)
        else $error("skipped word not discarded");
    a_iret_timing: assert property (tk && INSTR_I == OP_INTERRUPT_RETURN |=> !INSTR_READY_O ##1 DONE_O)
        else $error("interrupt return timing wrong");
    a_bit_one: assert property (tk && INSTR_I[9:2] == OP_MEMORY_BIT_SET_HI |=> DONE_O && INSTR_READY_O)
        else $error("bit set not one cycle");
    a_bank_hi: assert property (bk ##1 TABLE_READ_I |=> TABLE_PAGE_HI_O)
        else $error("bank flag not used");
    a_bank_once: assert property (TABLE_READ_I && !bk ##1 TABLE_READ_I && !bk |=> !TABLE_PAGE_HI_O)
        else $error("bank flag outlived one read");
    a_bad_addr: assert property (PSEL_I && PENABLE_I && PADDR_I > 8'h1C |-> PSLVERR_O)
        else $error("unmapped access without error");
    c_iret: cover property (tk && INSTR_I == OP_INTERRUPT_RETURN);
    c_bank: cover property (bk ##1 TABLE_READ_I);
    c_err: cover property (PSLVERR_O);
endmodule : rbs_exec_sva
bind rbs_exec rbs_exec_sva u_sva (.CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PADDR_I, .PSLVERR_O, .INSTR_VALID_I,
    .INSTR_I, .INSTR_READY_O, .DONE_O, .TABLE_READ_I, .TABLE_PAGE_HI_O, .SKIP_O);

// [tb/rbs_exec_tb_top.sv]
// Purpose: directed bench for rbs_exec
// Assumes: zero-wait apb, default stack depth 8
// Notes: registers primed over apb before each test's ops, except t_reset and t_bank
`timescale 1ns/100ps
module rbs_exec_tb_top
    import rbs_pkg::*;
;
    logic clk, rst, psel, pen, pwr, iv, tr, prdy, perr, irdy, done, phi, skip, er;
    logic [7:0] padr;
    logic [31:0] pwd, prd, rd;
    logic [9:0] ins;
    logic [PC_W-1:0] pc;
    int n_fail, check_count;
    rbs_exec dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .INSTR_VALID_I(iv), .INSTR_I(ins),
        .INSTR_READY_O(irdy), .DONE_O(done), .TABLE_READ_I(tr), .TABLE_PAGE_HI_O(phi), .PC_O(pc), .SKIP_O(skip));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // sel 0 pready, 1 instr ready, 2 done
    task automatic wait_hi(int sel);
        int c;
        c = 0;
        do begin
            @(posedge clk);
            c++;
            if (c > 20) begin
                n_fail++;
                complete_run();
            end
        end while ((sel == 0 ? prdy : sel == 1 ? irdy : done) !== 1'b1);
    endtask : wait_hi
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        wait_hi(0);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rdchk(string nm, logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rdchk
    task automatic ex(logic [9:0] op);
        @(posedge clk);
        iv <= 1'b1;
        ins <= op;
        wait_hi(1);
        iv <= 1'b0;
        wait_hi(2);
    endtask : ex
    task automatic pulse();
        @(posedge clk);
        tr <= 1'b1;
        @(posedge clk);
        tr <= 1'b0;
        #1;
    endtask : pulse
    task automatic t_reset();
        rdchk("pc", OFS_PC, 32'h0);
        rdchk("sp", OFS_SP, 32'h0);
        rdchk("status", OFS_STATUS, 32'h0);
        apb(1'b1, 8'h20, 32'h1);
        chk("slverr", {31'h0, er}, 32'h1);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ret();
        apb(1'b1, OFS_SP, 32'h3);
        apb(1'b1, OFS_STACK, 32'h1234);
        ex(OP_SUBROUTINE_RETURN);
        chk("pc", 32'(pc), 32'h1234);
        rdchk("sp", OFS_SP, 32'h2);
        apb(1'b1, OFS_SP, 32'h0);
        apb(1'b1, OFS_STACK, 32'h0ABC);
        ex(OP_SUBROUTINE_RETURN);
        chk("pc", 32'(pc), 32'h0ABC);
        rdchk("sp", OFS_SP, 32'h7);
        $display("t_ret done");
    endtask : t_ret
    task automatic t_skip();
        apb(1'b1, OFS_SP, 32'h1);
        apb(1'b1, OFS_STACK, 32'h0100);
        ex(OP_RETURN_SKIP);
        chk("pc", 32'(pc), 32'h0100);
        chk("skip", 32'(skip), 32'h1);
        apb(1'b1, OFS_PTR, 32'h0);
        apb(1'b1, OFS_MEM, 32'h0);
        ex({OP_MEMORY_BIT_SET_HI, 2'b01});
        chk("skip", 32'(skip), 32'h0);
        rdchk("mem", OFS_MEM, 32'h0);
        $display("t_skip done");
    endtask : t_skip
    task automatic t_bits();
        apb(1'b1, OFS_STATUS, 32'h20);
        apb(1'b1, OFS_PTR, 32'h02A5);
        apb(1'b1, OFS_MEM, 32'h4);
        for (int j = 0; j < 4; j++) begin
            ex({OP_MEMORY_BIT_SET_HI, 2'(j)});
            rdchk("mem", OFS_MEM, 32'h4 | ((32'h1 << (j + 1)) - 1));
        end
        rdchk("status", OFS_STATUS, 32'h20);
        $display("t_bits done");
    endtask : t_bits
    task automatic t_irq();
        apb(1'b1, OFS_PC, 32'h0155);
        apb(1'b1, OFS_SP, 32'h2);
        apb(1'b1, OFS_ACC, 32'h93);
        apb(1'b1, OFS_STATUS, 32'h0F);
        apb(1'b1, OFS_INT, 32'h1);
        apb(1'b1, OFS_PTR, 32'h0);
        apb(1'b1, OFS_ACC, 32'h0);
        apb(1'b1, OFS_STATUS, 32'h20);
        ex(OP_INTERRUPT_RETURN);
        chk("pc", 32'(pc), 32'h0155);
        rdchk("sp", OFS_SP, 32'h2);
        rdchk("ptr", OFS_PTR, 32'h02A5);
        rdchk("acc", OFS_ACC, 32'h93);
        rdchk("status", OFS_STATUS, 32'h2F);
        chk("skip", 32'(skip), 32'h1);
        ex(10'h000);
        chk("skip", 32'(skip), 32'h0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_bank();
        ex(OP_TABLE_BANK_SET);
        rdchk("status", OFS_STATUS, 32'h3E);
        pulse();
        chk("page", 32'(phi), 32'h1);
        pulse();
        chk("page", 32'(phi), 32'h0);
        $display("t_bank done");
    endtask : t_bank
    initial begin
        {rst, psel, pen, pwr, iv, tr} = 6'h20;
        padr = 8'h0;
        pwd = 32'h0;
        ins = 10'h0;
        n_fail = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ret();
        t_skip();
        t_bits();
        t_irq();
        t_bank();
        complete_run();
    end
endmodule : rbs_exec_tb_top
